//--- hw/gcd_defines.svh
// Register offsets, reset values and memory-cycle budgets of the command decoder
`ifndef GCD_DEFINES_SVH
`define GCD_DEFINES_SVH
`define GCD_OFF_CMD      8'h00
`define GCD_OFF_STATUS   8'h04
`define GCD_OFF_DX       8'h08
`define GCD_OFF_DY       8'h0C
`define GCD_OFF_SHORT    8'h10
`define GCD_OFF_CUR_X    8'h14
`define GCD_OFF_CUR_Y    8'h18
`define GCD_OFF_ARC_X    8'h1C
`define GCD_OFF_ARC_Y    8'h20
`define GCD_OFF_COUNT    8'h24
`define GCD_OFF_BOUND    8'h28
`define GCD_OFF_SRC_X    8'h2C
`define GCD_OFF_SRC_Y    8'h30
`define GCD_OFF_SRC_DY   8'h34
`define GCD_OFF_CELL     8'h38
`define GCD_OFF_REPEAT   8'h3C
`define GCD_RST_WORD     16'h0000
`define GCD_RST_REPEAT   8'h01
`define GCD_CLKS_PER_T   8
`define GCD_T_LINE_INIT  9'h005
`define GCD_T_LINE_LOOP  9'h004
`define GCD_T_ARC_INIT   9'h00F
`define GCD_T_ARC_LOOP   9'h00A
`define GCD_T_AREA_INIT  9'h00A
`define GCD_T_AREA_LOOP  9'h004
`define GCD_T_CELL_INIT  9'h004
`define GCD_T_CELL_LOOP  9'h006
`define GCD_T_VP_INIT    9'h002
`define GCD_T_VP_LOAD    9'h005
`define GCD_T_VP_SAVE    9'h004
`define GCD_T_VP_MODIFY  9'h00A
`define GCD_T_MOVE_HV    9'h003
`define GCD_T_MOVE_DIAG  9'h004
`define GCD_T_CONTROL    9'h001
`define GCD_T_BND_POLY   9'h004
`define GCD_T_BND_ARC    9'h008
`define GCD_CODE_NOP     8'hC0
`define GCD_CODE_ABORT   8'hFF
`define GCD_CY_READ      2'h2
`define GCD_CY_WRITE     2'h3
`define GCD_CY_DISPLAY   2'h1
`define GCD_CY_REFRESH   2'h0
`endif

//--- hw/gcd_pkg.sv
// Types shared by the drawing command decoder
package gcd_pkg;
  typedef enum logic [3:0] {
    GCD_ST_IDLE = 4'h1,
    GCD_ST_INIT = 4'h2,
    GCD_ST_LOOP = 4'h4,
    GCD_ST_BND  = 4'h8
  } gcd_state_t;
  typedef enum logic [1:0] {
    GCD_END_NONE = 2'h0,
    GCD_END_TGT  = 2'h1,
    GCD_END_SRC  = 2'h2
  } gcd_end_t;
  typedef logic [15:0] gcd_word_t;
endpackage

//--- hw/gcd_decoder.sv
// Drawing command decoder and memory-cycle sequencer with Avalon-MM registers
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "gcd_defines.svh"

// Operation
// - Line codes, 5T start, 4T per dot
// - Arc codes, 15T start, 10T loop
// - Area codes, 10T start, polyarc 15T
// - Cell print codes, 4T start, 6T/word
// - Viewport codes, 2T start, 5/4/10T loops
// - Cursor move codes, 3/3/4T
// - 0xC0 no-op, 0xFF abort, 1T each
// - Destination mask adds one cycle per pel
// - Pel size bit; long pels add 2T to pen lines and arcs
// - Short relative bit selects short displacement
// - Pen and polarity bits choose pen
// - Fill start bit begins new fill
// - Viewport source pointer auto-increment direction
// - Repeat bit steps cell over window
// - Source mask adds three loop cycles; transparent print codes set the source mask without them
// - Down and left bits set direction
// - Transparent print skips colour zero pels
// - Destination deltas signed, source X unsigned
// - Memory cycle equals eight clocks
// - Loop extensions for masks and pens
// - Fill boundary pels add 4T/8T
// - Commands run only outside display slots
// - Two-bit cycle type per memory cycle
module gcd_decoder (
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic [7:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out,
  input  wire logic              display_due_in,
  input  wire logic              refresh_due_in,
  input  wire logic [7:0]        pel_color_in,
  output logic [1:0]             cycle_type_out,
  output logic                   cycle_start_out,
  output logic                   pel_write_out,
  output logic                   busy_out,
  output logic                   dest_mask_out,
  output logic                   src_mask_out,
  output logic                   short_pel_out,
  output logic [1:0]             pen_mode_out
);
  import gcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  gcd_state_t  state_ff;
  gcd_end_t    end_ff;
  gcd_word_t   dx_ff, dy_ff, short_ff, cur_x_ff, cur_y_ff, arc_x_ff, arc_y_ff;
  gcd_word_t   count_ff, bound_ff, src_x_ff, src_y_ff, src_dy_ff, cell_ff;
  gcd_word_t   tgt_x_ff, tgt_y_ff;
  logic [7:0]  repeat_ff, code_ff;
  logic [2:0]  div_ff;
  logic [8:0]  phase_ff, loop_t_ff, bnd_t_ff;
  logic [23:0] units_ff;
  logic [15:0] bnd_units_ff;
  logic        abort_ff, vp_inc_ff, vp_xft_ff, transp_ff, fill_open_ff;

  // Decode results
  logic        dec_ok, dec_abort, dec_vp, dec_fill, dec_rep;
  logic [8:0]  dec_init, dec_loop, dec_bnd;
  logic [23:0] dec_units;
  gcd_end_t    dec_end;
  gcd_word_t   dec_tx, dec_ty, sel_dx, sel_dy, mag_dx, mag_dy;
  logic [7:0]  wcode;

  logic        wr_fire, rd_take, mem_tick, cmd_slot, cmd_fire, unit_end;
  logic [1:0]  cmd_type;

  function automatic gcd_word_t merge16(input gcd_word_t old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the request completes
  assign wr_fire  = avs_write_in && !avs_waitrequest_out;
  assign rd_take  = avs_read_in && avs_waitrequest_out;
  assign wcode    = avs_writedata_in[7:0];
  assign cmd_fire = wr_fire && avs_address_in == `GCD_OFF_CMD && avs_byteenable_in[0]
                    && state_ff == GCD_ST_IDLE && dec_ok;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      avs_waitrequest_out <= 1'b1;
    else if ((avs_read_in || avs_write_in) && avs_waitrequest_out)
      avs_waitrequest_out <= 1'b0;
    else
      avs_waitrequest_out <= 1'b1;
  end

  // Read mux; unmapped offsets answer zero
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      avs_readdata_out <= 32'h0000_0000;
    else if (rd_take)
    begin
      unique case (avs_address_in)
        `GCD_OFF_CMD:    avs_readdata_out <= {24'h00_0000, code_ff};
        `GCD_OFF_STATUS: avs_readdata_out <= {27'h000_0000, fill_open_ff, abort_ff,
                                              cycle_type_out, busy_out};
        `GCD_OFF_DX:     avs_readdata_out <= {16'h0000, dx_ff};
        `GCD_OFF_DY:     avs_readdata_out <= {16'h0000, dy_ff};
        `GCD_OFF_SHORT:  avs_readdata_out <= {16'h0000, short_ff};
        `GCD_OFF_CUR_X:  avs_readdata_out <= {16'h0000, cur_x_ff};
        `GCD_OFF_CUR_Y:  avs_readdata_out <= {16'h0000, cur_y_ff};
        `GCD_OFF_ARC_X:  avs_readdata_out <= {16'h0000, arc_x_ff};
        `GCD_OFF_ARC_Y:  avs_readdata_out <= {16'h0000, arc_y_ff};
        `GCD_OFF_COUNT:  avs_readdata_out <= {16'h0000, count_ff};
        `GCD_OFF_BOUND:  avs_readdata_out <= {16'h0000, bound_ff};
        `GCD_OFF_SRC_X:  avs_readdata_out <= {16'h0000, src_x_ff};
        `GCD_OFF_SRC_Y:  avs_readdata_out <= {16'h0000, src_y_ff};
        `GCD_OFF_SRC_DY: avs_readdata_out <= {16'h0000, src_dy_ff};
        `GCD_OFF_CELL:   avs_readdata_out <= {16'h0000, cell_ff};
        `GCD_OFF_REPEAT: avs_readdata_out <= {24'h00_0000, repeat_ff};
        default:         avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Argument registers; cursor and source pointer are also moved by commands
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      dx_ff     <= `GCD_RST_WORD;
      dy_ff     <= `GCD_RST_WORD;
      short_ff  <= `GCD_RST_WORD;
      arc_x_ff  <= `GCD_RST_WORD;
      arc_y_ff  <= `GCD_RST_WORD;
      count_ff  <= `GCD_RST_WORD;
      bound_ff  <= `GCD_RST_WORD;
      src_dy_ff <= `GCD_RST_WORD;
      cell_ff   <= `GCD_RST_WORD;
      repeat_ff <= `GCD_RST_REPEAT;
    end
    else if (wr_fire)
    begin
      unique case (avs_address_in)
        `GCD_OFF_DX:     dx_ff     <= merge16(dx_ff, avs_writedata_in, avs_byteenable_in);
        `GCD_OFF_DY:     dy_ff     <= merge16(dy_ff, avs_writedata_in, avs_byteenable_in);
        `GCD_OFF_SHORT:  short_ff  <= merge16(short_ff, avs_writedata_in, avs_byteenable_in);
        `GCD_OFF_ARC_X:  arc_x_ff  <= merge16(arc_x_ff, avs_writedata_in, avs_byteenable_in);
        `GCD_OFF_ARC_Y:  arc_y_ff  <= merge16(arc_y_ff, avs_writedata_in, avs_byteenable_in);
        `GCD_OFF_COUNT:  count_ff  <= merge16(count_ff, avs_writedata_in, avs_byteenable_in);
        `GCD_OFF_BOUND:  bound_ff  <= merge16(bound_ff, avs_writedata_in, avs_byteenable_in);
        `GCD_OFF_SRC_DY: src_dy_ff <= merge16(src_dy_ff, avs_writedata_in, avs_byteenable_in);
        `GCD_OFF_CELL:   cell_ff   <= merge16(cell_ff, avs_writedata_in, avs_byteenable_in);
        `GCD_OFF_REPEAT: repeat_ff <= avs_byteenable_in[0] ? wcode : repeat_ff;
        default:         ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and cost budget
  // short relative displacement
  assign sel_dx = wcode[0] ? {{8{short_ff[7]}}, short_ff[7:0]} : dx_ff;
  assign sel_dy = wcode[0] ? {{8{short_ff[15]}}, short_ff[15:8]} : dy_ff;
  assign mag_dx = sel_dx[15] ? 16'(-sel_dx) : sel_dx;
  assign mag_dy = sel_dy[15] ? 16'(-sel_dy) : sel_dy;

  always_comb
  begin
    dec_ok    = 1'b1;
    dec_abort = 1'b0;
    dec_vp    = 1'b0;
    dec_fill  = 1'b0;
    dec_rep   = 1'b0;
    dec_init  = `GCD_T_CONTROL;
    dec_loop  = 9'h000;
    dec_bnd   = 9'h000;
    dec_units = 24'h00_0000;
    dec_end   = GCD_END_TGT;
    dec_tx    = 16'(cur_x_ff + sel_dx);
    dec_ty    = 16'(cur_y_ff + sel_dy);
    // control codes first: abort shares the rectangle prefix
    if (wcode == `GCD_CODE_ABORT)
    begin
      dec_abort = 1'b1;
      dec_end   = GCD_END_NONE;
    end
    else if (wcode == `GCD_CODE_NOP)
      dec_end = GCD_END_NONE;
    else
    begin
      casez (wcode)
        8'b000?_????:
        begin
          dec_init  = `GCD_T_LINE_INIT;
          dec_loop  = `GCD_T_LINE_LOOP;
          dec_units = {8'h00, count_ff};
        end
        8'b001?_????:
        begin
          dec_init  = `GCD_T_ARC_INIT;
          dec_loop  = `GCD_T_ARC_LOOP;
          dec_units = {8'h00, count_ff};
          dec_tx    = arc_x_ff;
          dec_ty    = arc_y_ff;
        end
        8'b1111_0???, 8'b0101_0???:
        begin
          dec_init  = `GCD_T_AREA_INIT;
          dec_loop  = `GCD_T_AREA_LOOP;
          dec_units = {8'h00, count_ff};
          if (wcode[7])
            dec_tx = cur_x_ff;
        end
        8'b0100_????, 8'b0110_????:
        begin
          dec_fill  = 1'b1;
          dec_init  = wcode[5] ? `GCD_T_ARC_INIT : `GCD_T_AREA_INIT;
          dec_loop  = `GCD_T_AREA_LOOP;
          dec_bnd   = wcode[5] ? `GCD_T_BND_ARC : `GCD_T_BND_POLY;
          dec_units = {8'h00, count_ff};
          if (wcode[5])
          begin
            dec_tx = arc_x_ff;
            dec_ty = arc_y_ff;
          end
        end
        // cell printing ends on the start row
        8'b1011_????, 8'b100?_??1?, 8'b1010_??1?:
        begin
          dec_rep  = wcode[3];
          dec_init = `GCD_T_CELL_INIT;
          dec_loop = `GCD_T_CELL_LOOP;
          dec_ty   = cur_y_ff;
          // step and repeat over the window
          dec_units = dec_rep ? 24'(count_ff * repeat_ff) : {8'h00, count_ff};
        end
        // viewport transfers; code 11 in the op field is not a command
        8'b1110_????:
        begin
          dec_vp    = 1'b1;
          dec_init  = `GCD_T_VP_INIT;
          dec_units = {8'h00, count_ff};
          dec_end   = GCD_END_SRC;
          unique case (wcode[2:1])
            2'b00:   dec_loop = `GCD_T_VP_LOAD;
            2'b01:   dec_loop = `GCD_T_VP_SAVE;
            2'b10:   dec_loop = `GCD_T_VP_MODIFY;
            default: dec_ok = 1'b0;
          endcase
        end
        // vertical move, down bit in bit1
        8'b1100_01??:
        begin
          dec_init = `GCD_T_MOVE_HV;
          dec_tx   = cur_x_ff;
          dec_ty   = wcode[1] ? 16'(cur_y_ff + mag_dy) : 16'(cur_y_ff - mag_dy);
        end
        8'b1101_????:
        begin
          dec_init = wcode[2] ? `GCD_T_MOVE_DIAG : `GCD_T_MOVE_HV;
          dec_tx   = wcode[3] ? 16'(cur_x_ff - mag_dx) : 16'(cur_x_ff + mag_dx);
          if (!wcode[2])
            dec_ty = cur_y_ff;
          else
            dec_ty = wcode[1] ? 16'(cur_y_ff + mag_dy) : 16'(cur_y_ff - mag_dy);
          if (wcode[1:0] == 2'b10 && !wcode[2])
            dec_ok = 1'b0;
        end
        default: dec_ok = 1'b0;
      endcase
      // destination mask costs one cycle per pel
      if (!dec_vp && wcode[2] && (dec_units != 24'h00_0000))
        dec_loop = 9'(dec_loop + 9'h001);
      // Moves and control codes use bit 2 as part of the code, not as a
      // mask bit, so they never pay the extra cycle
      // source mask and mask printing extras
      if (wcode[7:5] == 3'b100 && wcode[4])
        dec_loop = 9'(dec_loop + 9'h003);
      // pen lines and arcs use a cell pen
      if (wcode[7:6] == 2'b00 && wcode[3])
      begin
        dec_loop = 9'(dec_loop + cell_ff[8:0]);
        if (!wcode[1])
          dec_loop = 9'(dec_loop + 9'h002);
        if (wcode[4])
          dec_loop = 9'(dec_loop + 9'h003);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory-cycle slots
  // one slot every eight clocks
  assign mem_tick = (div_ff == 3'(`GCD_CLKS_PER_T - 1));
  // display and refresh take the slot first
  assign cmd_slot = mem_tick && !display_due_in && !refresh_due_in
                    && state_ff != GCD_ST_IDLE;
  assign unit_end = (phase_ff == 9'h001);
  assign cmd_type = (state_ff != GCD_ST_INIT && unit_end) ? `GCD_CY_WRITE : `GCD_CY_READ;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      div_ff <= 3'h0;
    else
      div_ff <= 3'(div_ff + 3'h1);
  end

  // cycle type and start strobe per slot
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      cycle_type_out  <= `GCD_CY_REFRESH;
      cycle_start_out <= 1'b0;
      pel_write_out   <= 1'b0;
    end
    else
    begin
      cycle_start_out <= mem_tick && (display_due_in || refresh_due_in || cmd_slot);
      // colour zero pels are not written in transparent print
      pel_write_out   <= cmd_slot && !abort_ff && cmd_type == `GCD_CY_WRITE
                         && (!transp_ff || pel_color_in != 8'h00);
      if (mem_tick && display_due_in)
        cycle_type_out <= `GCD_CY_DISPLAY;
      else if (mem_tick && refresh_due_in)
        cycle_type_out <= `GCD_CY_REFRESH;
      else if (cmd_slot)
        cycle_type_out <= cmd_type;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_ff     <= GCD_ST_IDLE;
      phase_ff     <= 9'h000;
      loop_t_ff    <= 9'h000;
      bnd_t_ff     <= 9'h000;
      units_ff     <= 24'h00_0000;
      bnd_units_ff <= 16'h0000;
      end_ff       <= GCD_END_NONE;
    end
    else if (cmd_fire)
    begin
      state_ff     <= GCD_ST_INIT;
      phase_ff     <= dec_init;
      loop_t_ff    <= dec_loop;
      bnd_t_ff     <= dec_bnd;
      units_ff     <= dec_units;
      bnd_units_ff <= (dec_bnd != 9'h000) ? bound_ff : 16'h0000;
      end_ff       <= dec_end;
    end
    else if (cmd_slot)
    begin
      // abort ends the command at this boundary
      if (abort_ff)
        state_ff <= GCD_ST_IDLE;
      else if (!unit_end)
        phase_ff <= 9'(phase_ff - 9'h001);
      else if (state_ff == GCD_ST_LOOP && units_ff != 24'h00_0001)
      begin
        units_ff <= 24'(units_ff - 24'h00_0001);
        phase_ff <= loop_t_ff;
      end
      else if (state_ff == GCD_ST_BND && bnd_units_ff != 16'h0001)
      begin
        bnd_units_ff <= 16'(bnd_units_ff - 16'h0001);
        phase_ff     <= bnd_t_ff;
      end
      else if (state_ff == GCD_ST_INIT && units_ff != 24'h00_0000)
      begin
        state_ff <= GCD_ST_LOOP;
        phase_ff <= loop_t_ff;
      end
      else if (state_ff != GCD_ST_BND && bnd_units_ff != 16'h0000)
      begin
        state_ff <= GCD_ST_BND;
        phase_ff <= bnd_t_ff;
      end
      else
        state_ff <= GCD_ST_IDLE;
    end
  end

  // Abort request: a busy sequencer is stopped, an idle one runs it as 1T
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      abort_ff <= 1'b0;
    else if (wr_fire && avs_address_in == `GCD_OFF_CMD && avs_byteenable_in[0]
             && wcode == `GCD_CODE_ABORT)
      abort_ff <= 1'b1;
    else if (cmd_slot || state_ff == GCD_ST_IDLE)
      abort_ff <= 1'b0;
  end

  // Per-command mode flags and status
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      code_ff       <= 8'h00;
      busy_out      <= 1'b0;
      dest_mask_out <= 1'b0;
      src_mask_out  <= 1'b0;
      short_pel_out <= 1'b0;
      pen_mode_out  <= 2'h0;
      transp_ff     <= 1'b0;
      vp_inc_ff     <= 1'b0;
      vp_xft_ff     <= 1'b0;
      fill_open_ff  <= 1'b0;
      tgt_x_ff      <= `GCD_RST_WORD;
      tgt_y_ff      <= `GCD_RST_WORD;
    end
    else if (cmd_fire)
    begin
      code_ff       <= wcode;
      busy_out      <= !dec_abort;
      // destination mask applied to written pels
      dest_mask_out <= wcode[2] && (wcode[7:6] != 2'b11 || wcode[7:3] == 5'b11110);
      src_mask_out  <= (wcode[7:5] == 3'b100 && wcode[4]) || (wcode[7:4] == 4'b1010);
      short_pel_out <= wcode[1];
      // 0 single pel, 1 cell, 3 masked object
      pen_mode_out  <= (wcode[7:6] == 2'b00) ? {wcode[3] & wcode[4], wcode[3]} : 2'h0;
      transp_ff     <= (wcode[7:4] == 4'b1010);
      vp_inc_ff     <= dec_vp && wcode[0];
      vp_xft_ff     <= wcode[3];
      // a set start bit opens a fresh fill
      if (dec_fill)
        fill_open_ff <= wcode[3] | fill_open_ff;
      tgt_x_ff      <= dec_tx;
      tgt_y_ff      <= dec_ty;
    end
    else if (state_ff == GCD_ST_IDLE)
      busy_out <= 1'b0;
  end

  // Cursor: host writes while idle, commands set their end position
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      cur_x_ff <= `GCD_RST_WORD;
      cur_y_ff <= `GCD_RST_WORD;
    end
    else if (busy_out && state_ff == GCD_ST_IDLE && end_ff == GCD_END_TGT)
    begin
      cur_x_ff <= tgt_x_ff;
      cur_y_ff <= tgt_y_ff;
    end
    else if (busy_out && state_ff == GCD_ST_IDLE && end_ff == GCD_END_SRC)
    begin
      cur_x_ff <= src_x_ff;
      cur_y_ff <= src_y_ff;
    end
    else if (wr_fire && !busy_out && avs_address_in == `GCD_OFF_CUR_X)
      cur_x_ff <= merge16(cur_x_ff, avs_writedata_in, avs_byteenable_in);
    else if (wr_fire && !busy_out && avs_address_in == `GCD_OFF_CUR_Y)
      cur_y_ff <= merge16(cur_y_ff, avs_writedata_in, avs_byteenable_in);
  end

  // source pointer steps once per viewport word
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      src_x_ff <= `GCD_RST_WORD;
      src_y_ff <= `GCD_RST_WORD;
    end
    else if (cmd_slot && !abort_ff && state_ff == GCD_ST_LOOP && unit_end && vp_inc_ff)
    begin
      // X only counts up; Y follows the sign of the source step
      if (vp_xft_ff)
        src_x_ff <= 16'(src_x_ff + 16'h0001);
      else
        src_y_ff <= src_dy_ff[15] ? 16'(src_y_ff - 16'h0001) : 16'(src_y_ff + 16'h0001);
    end
    else if (wr_fire && !busy_out && avs_address_in == `GCD_OFF_SRC_X)
      src_x_ff <= merge16(src_x_ff, avs_writedata_in, avs_byteenable_in);
    else if (wr_fire && !busy_out && avs_address_in == `GCD_OFF_SRC_Y)
      src_y_ff <= merge16(src_y_ff, avs_writedata_in, avs_byteenable_in);
  end
endmodule // gcd_decoder
`default_nettype wire

//--- bench/gcd_mem_model.sv
// Memory controller model that schedules display and refresh slots
`timescale 1ns/100ps
`default_nettype none
module gcd_mem_model (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  output logic            display_due_out,
  output logic            refresh_due_out,
  output logic [7:0]      pel_color_out
);
  logic [7:0] phase_ff;
  // Free-running phase; display and refresh overlap once so priority is exercised
  always_ff @(posedge clk_in)
  begin
    if (reset_in) phase_ff <= 8'h00;
    else phase_ff <= phase_ff + 8'h01;
  end
  assign display_due_out = (phase_ff[5:3] == 3'h2) || (phase_ff[5:3] == 3'h3);
  assign refresh_due_out = (phase_ff[5:3] == 3'h3) || (phase_ff[5:3] == 3'h6);
  assign pel_color_out   = {3'h0, phase_ff[7:3]};  // Zero in one slot a lap: transparent pels
endmodule // gcd_mem_model
`default_nettype wire

//--- bench/gcd_decoder_asserts.sv
// Port checker for the drawing command decoder
`timescale 1ns/100ps
`default_nettype none
module gcd_decoder_asserts (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       display_due_in,
  input wire logic       refresh_due_in,
  input wire logic [1:0] cycle_type_out,
  input wire logic       cycle_start_out,
  input wire logic       pel_write_out,
  input wire logic       busy_out,
  input wire logic [1:0] pen_mode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // A performed slot and the quiet clocks that must follow it
  sequence s_slot;
    cycle_start_out;
  endsequence
  sequence s_quiet;
    !cycle_start_out [*7];
  endsequence
  a_slot_every_eight: assert property (s_slot |=> s_quiet)
    else $error("slot pulses closer than eight clocks");
  a_display_wins: assert property (
    s_slot and $past(display_due_in) |-> cycle_type_out == 2'h1)
    else $error("display slot not granted");
  a_refresh_next: assert property (
    s_slot and !$past(display_due_in) && $past(refresh_due_in) |-> cycle_type_out == 2'h0)
    else $error("refresh slot not granted");
  a_cmd_free_slot: assert property (
    s_slot and cycle_type_out[1] |-> !$past(display_due_in) && !$past(refresh_due_in))
    else $error("command cycle in a reserved slot");
  a_pel_on_write: assert property (
    pel_write_out |-> cycle_start_out && cycle_type_out == 2'h3)
    else $error("pel write outside a write cycle");
  a_type_holds: assert property (!cycle_start_out |-> $stable(cycle_type_out))
    else $error("cycle type changed between slots");
  a_pen_legal: assert property (pen_mode_out != 2'h2)
    else $error("illegal pen mode");
  a_pel_when_busy: assert property (pel_write_out |-> busy_out || $past(busy_out))
    else $error("pel written while idle");
endmodule // gcd_decoder_asserts
bind gcd_decoder gcd_decoder_asserts gcd_decoder_asserts_inst (.clk_in, .reset_in,
  .display_due_in, .refresh_due_in, .cycle_type_out, .cycle_start_out, .pel_write_out,
  .busy_out, .pen_mode_out);
`default_nettype wire

//--- bench/gcd_decoder_tb.sv
// Bench: command costs, cursor moves, busy refusal and abort
`timescale 1ns/100ps
`default_nettype none
`include "gcd_defines.svh"
module gcd_decoder_tb;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  avs_address_in = 8'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out, rd, x0;
  logic        avs_waitrequest_out, display_due, refresh_due, cycle_start_out, busy_out;
  logic [7:0]  pel_color;
  logic        dest_mask, src_mask, short_pel;
  logic [1:0]  cycle_type_out, pen_mode;
  int          num_errors = 0, num_checks = 0, cmd_cycles = 0, base;
  // Codes and costs in memory cycles with COUNT, BOUND and REPEAT all 1
  localparam logic [7:0] CODES [16] = '{8'hC0, 8'h03, 8'h07, 8'h23, 8'hF3, 8'h4B, 8'h6B,
    8'hB3, 8'h93, 8'hA3, 8'hE0, 8'hE2, 8'hE4, 8'hD1, 8'hD7, 8'hC7};
  localparam int COSTS [16] = '{1, 9, 10, 25, 14, 18, 27, 10, 13, 10, 7, 6, 12, 3, 4, 3};
  always #2.5 clk_in = ~clk_in;
  gcd_mem_model gcd_mem_model_inst (.clk_in, .reset_in, .display_due_out(display_due),
    .refresh_due_out(refresh_due), .pel_color_out(pel_color));
  gcd_decoder gcd_decoder_inst (.clk_in, .reset_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hF), .avs_readdata_out,
    .avs_waitrequest_out, .display_due_in(display_due), .refresh_due_in(refresh_due),
    .pel_color_in(pel_color), .cycle_type_out, .cycle_start_out, .pel_write_out(),
    .busy_out, .dest_mask_out(dest_mask), .src_mask_out(src_mask), .short_pel_out(short_pel),
    .pen_mode_out(pen_mode));
  // Count command memory cycles as they are performed
  always @(posedge clk_in)
    if (cycle_start_out === 1'b1 && cycle_type_out[1] === 1'b1) cmd_cycles++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 64);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n >= 64) num_errors++;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    @(posedge clk_in);
    while (busy_out !== 1'b0 && n < 4000)
    begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 4000) num_errors++;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic run(input logic [7:0] code, input int exp);
    base = cmd_cycles;
    bus(1'b1, `GCD_OFF_CMD, {24'h0, code});
    wait_idle();
    check(32'(cmd_cycles - base), 32'(exp));
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    bus(1'b0, `GCD_OFF_REPEAT, 32'h0);
    check(rd, 32'h1);
    bus(1'b0, 8'h80, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `GCD_OFF_COUNT, 32'h1);
    bus(1'b1, `GCD_OFF_BOUND, 32'h1);
    bus(1'b1, `GCD_OFF_SHORT, 32'h0203);
    // Cost of each code in CODES, display and refresh slots excluded
    for (int i = 0; i < 16; i++)
      run(CODES[i], COSTS[i]);
    // Pen options, transparent print, repeat and viewport stepping
    run(8'h1C, 15);
    check({27'h0, pen_mode, short_pel, src_mask, dest_mask}, 32'h19);
    run(8'hA3, 10);
    check({27'h0, pen_mode, short_pel, src_mask, dest_mask}, 32'h06);
    bus(1'b1, `GCD_OFF_REPEAT, 32'h3);
    run(8'hBB, 22);
    run(8'hE9, 7);
    bus(1'b0, `GCD_OFF_CUR_X, 32'h0);
    check(rd, 32'h1);
    x0 = rd;
    run(8'hD1, 3);
    bus(1'b0, `GCD_OFF_CUR_X, 32'h0);
    check(rd, (x0 + 32'h3) & 32'hFFFF);
    run(8'hD9, 3);
    bus(1'b0, `GCD_OFF_CUR_X, 32'h0);
    check(rd, x0);
    // A code written while busy is dropped; abort (0xFF) stops the running command
    bus(1'b1, `GCD_OFF_COUNT, 32'h28);
    base = cmd_cycles;
    bus(1'b1, `GCD_OFF_CMD, 32'h03);
    bus(1'b1, `GCD_OFF_CMD, 32'hC0);
    bus(1'b0, `GCD_OFF_CMD, 32'h0);
    check(rd, 32'h03);
    bus(1'b1, `GCD_OFF_CMD, 32'hFF);
    wait_idle();
    check(32'(cmd_cycles - base < 20), 32'h1);
    run(8'hC0, 1);
    results();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge clk_in);
    num_errors++;
    results();
  end
endmodule // gcd_decoder_tb
`default_nettype wire
